/* File: hdl/acris_pkg.sv */
// shared constants and types for the converter clock, reset and input-select block
package acris_pkg;
  // register map, byte addresses
  localparam logic [11:0] ACRIS_CTRL_ADDR = 12'h000;
  localparam logic [11:0] ACRIS_STATUS_ADDR = 12'h004;
  localparam logic [11:0] ACRIS_ID_ADDR = 12'h008;
  // arbitrary neutral value
  localparam logic [31:0] ACRIS_ID_VALUE = 32'h0000_a5c1;

  // ctrl field positions
  localparam int ACRIS_SEL_LSB = 0;
  localparam int ACRIS_GAIN_LSB = 4;
  localparam int ACRIS_MODE_LSB = 12;

  // values after reset
  localparam logic [2:0] ACRIS_SEL_RESET = 3'h1;
  localparam logic [5:0] ACRIS_GAIN_RESET = 6'h0a;
  localparam logic [1:0] ACRIS_MODE_RESET = 2'h0;

  // legal gain codes, others mute
  localparam logic [5:0] ACRIS_GAIN_MIN = 6'h0a;
  localparam logic [5:0] ACRIS_GAIN_MAX = 6'h36;

  // input select codes meaning mute
  localparam logic [2:0] ACRIS_SEL_MUTE_LO = 3'h0;
  localparam logic [2:0] ACRIS_SEL_MUTE_HI = 3'h7;

  // clock ratios as master clocks per sample
  localparam logic [9:0] ACRIS_RATIO_256 = 10'h100;
  localparam logic [9:0] ACRIS_RATIO_384 = 10'h180;
  localparam logic [9:0] ACRIS_RATIO_512 = 10'h200;
  localparam logic [9:0] ACRIS_RATIO_768 = 10'h300;
  // classification limits, midway between ratios
  localparam logic [9:0] ACRIS_LIM_320 = 10'h140;
  localparam logic [9:0] ACRIS_LIM_448 = 10'h1c0;
  localparam logic [9:0] ACRIS_LIM_640 = 10'h280;

  // reset hold in master clocks, then valid delay in sample periods
  localparam logic [10:0] ACRIS_HOLD_CLOCKS = 11'h400;
  localparam int ACRIS_VALID_FRAMES = 4500;
  localparam int ACRIS_BITS_PER_FRAME = 64;

  // bus clock and the slowest rate at which 768x may not be used
  localparam int ACRIS_PCLK_HZ = 10_000_000;
  localparam int ACRIS_FS_LIMIT_HZ = 88_200;
  localparam logic [15:0] ACRIS_FS_LIMIT_CYCLES = 16'(ACRIS_PCLK_HZ / ACRIS_FS_LIMIT_HZ);

  typedef enum logic [1:0] {
    ACRIS_R256 = 2'b00,
    ACRIS_R384 = 2'b01,
    ACRIS_R512 = 2'b10,
    ACRIS_R768 = 2'b11
  } acris_ratio_t;

  typedef enum logic [1:0] {
    ACRIS_SLAVE = 2'b00,
    ACRIS_MASTER_256 = 2'b01,
    ACRIS_MASTER_384 = 2'b10,
    ACRIS_MASTER_512 = 2'b11
  } acris_mode_t;

  typedef struct packed {
    acris_mode_t mode;
    logic [5:0] gain;
    logic [2:0] sel;
  } acris_ctrl_t;

  typedef struct packed {
    logic filter_clk;
    logic mod_clk;
    logic frame_clk;
    logic frame_tick;
  } acris_clks_t;
endpackage

/* File: hdl/acris_clk_div.sv */
// divides master clock ticks into filter, modulator, bit and frame clocks
`timescale 1ns/10ps
module acris_clk_div
  import acris_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick,
  input wire acris_ratio_t ratio,
  output acris_clks_t clks
);
  logic [2:0] cnt;
  logic [4:0] bit_cnt;
  logic mod_ph;
  logic frame_ph;
  wire logic [2:0] div_len;
  wire logic [2:0] half_len;
  wire logic wrap;
  wire logic bit_wrap;

  // ticks per filter clock period: ratio / 128
  assign div_len = (ratio == ACRIS_R256) ? 3'd2 :
                   (ratio == ACRIS_R384) ? 3'd3 :
                   (ratio == ACRIS_R512) ? 3'd4 : 3'd6;
  // odd length keeps the longer half high
  assign half_len = 3'((div_len + 3'd1) >> 1);
  assign wrap = tick && (cnt == 3'(div_len - 3'd1));
  assign bit_wrap = wrap && mod_ph && (bit_cnt == 5'h1f);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'd0;
      bit_cnt <= 5'd0;
      mod_ph <= 1'b0;
      frame_ph <= 1'b0;
      clks <= '0;
    end else if (clear) begin
      cnt <= 3'd0;
      bit_cnt <= 5'd0;
      mod_ph <= 1'b0;
      frame_ph <= 1'b0;
      clks <= '0;
    end else begin
      clks.frame_tick <= 1'b0;
      if (tick) begin
        cnt <= wrap ? 3'd0 : 3'(cnt + 3'd1);
        // filter at 128 fs
        clks.filter_clk <= wrap ? 1'b1 : (3'(cnt + 3'd1) < half_len);
      end
      if (wrap) begin
        // modulator at 64 fs, also the bit clock
        mod_ph <= ~mod_ph;
        clks.mod_clk <= ~mod_ph;
        if (mod_ph) begin
          bit_cnt <= 5'(bit_cnt + 5'd1);
        end
      end
      if (bit_wrap) begin
        // one frame per 64 bit clocks
        frame_ph <= ~frame_ph;
        clks.frame_clk <= ~frame_ph;
        clks.frame_tick <= ~frame_ph;
      end
    end
  end
endmodule

/* File: hdl/acris_top.sv */
// clock ratio detect, clock division, power-on reset and input select control
// Contract
// - master clock may be 256, 384, 512 or 768 times the sample rate.
// - in slave mode the ratio is measured from the frame clock.
// - 768x never in master mode, nor in slave mode at 88.2/96 kHz (slave mode only flags it in ratio_err, the divider keeps 768x).
// - divide master clock to 128 fs filter and 64 fs modulator clocks.
// - hold reset 1024 master clocks after supply good; outputs read zero.
// - samples invalid until 4500 sample periods after reset release.
// - reset release must not need the master clock at that moment.
// - input and gain selections apply immediately when written.
// - selection changes are abrupt, with no zero-cross or smoothing.
// - select codes 1..6 pick inputs; 0 and 7 mute; default input 1.
// - mode 00 slave (default); 01, 10, 11 master at 256, 384, 512.
// - in master mode drive bit and frame clocks, bit = 64 x frame.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module acris_top
  import acris_pkg::*;
#(
  parameter int VALID_FRAMES = ACRIS_VALID_FRAMES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clock_in,
  input wire logic supply_good,
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  output logic filter_clk,
  output logic mod_clk,
  output logic core_reset,
  output logic [2:0] input_select,
  output logic input_mute,
  output logic [5:0] pga_gain,
  output logic pga_mute,
  input wire logic [23:0] sample_in,
  input wire logic sample_strobe,
  output logic [23:0] sample_out,
  output logic sample_out_strobe,
  output logic data_valid
);
  // power-up sequence: hold, then settle, then valid
  typedef enum logic [1:0] {
    ACRIS_PWR_HOLD = 2'b00,
    ACRIS_PWR_SETTLE = 2'b01,
    ACRIS_PWR_VALID = 2'b10
  } acris_pwr_t;

  acris_ctrl_t ctrl;
  acris_ratio_t detected_ratio;
  acris_clks_t clks;
  logic mclk_prev;
  logic frame_prev;
  logic [9:0] tick_count;
  logic [15:0] period_count;
  logic [15:0] frame_period;
  logic [10:0] hold_count;
  logic [12:0] valid_count;
  logic ratio_seen;
  acris_pwr_t pwr_state;
  acris_pwr_t next_pwr;

  // bus decode
  wire logic bus_access;
  wire logic bus_write;
  wire logic hit_ctrl;
  wire logic hit_status;
  wire logic hit_id;
  wire logic hit_any;
  wire logic [31:0] ctrl_word;
  wire logic [31:0] status_word;
  wire logic [31:0] read_mux;
  wire acris_ctrl_t next_ctrl;
  wire logic bus_setup;
  wire logic next_pslverr;
  wire logic [31:0] next_prdata;

  // link side events
  wire logic mclk_tick;
  wire logic frame_rise;
  wire logic is_master;
  wire acris_ratio_t active_ratio;
  wire acris_ratio_t next_detected;
  wire logic ratio_err;
  wire logic hold_done;
  wire logic frame_event;
  wire logic valid_done;
  wire logic [2:0] next_select;
  wire logic sel_mute;
  wire logic gain_mute;
  wire logic next_core_reset;
  wire logic next_data_valid;

  assign bus_access = psel && penable && pready;
  assign bus_write = bus_access && pwrite;
  assign hit_ctrl = (paddr == ACRIS_CTRL_ADDR);
  assign hit_status = (paddr == ACRIS_STATUS_ADDR);
  assign hit_id = (paddr == ACRIS_ID_ADDR);
  assign hit_any = hit_ctrl || hit_status || hit_id;
  assign bus_setup = psel && !penable;

  assign ctrl_word = {18'h0, ctrl.mode, 2'h0, ctrl.gain, 1'b0, ctrl.sel};
  assign status_word = {25'h0, data_valid, core_reset, ratio_err, is_master,
                        ratio_seen, active_ratio};
  assign read_mux = hit_ctrl ? ctrl_word :
                    hit_status ? status_word :
                    hit_id ? ACRIS_ID_VALUE : 32'h0000_0000;

  // the mode field carries no 768x code, so master mode cannot select it
  assign next_ctrl.sel = pwdata[ACRIS_SEL_LSB +: 3];
  assign next_ctrl.gain = pwdata[ACRIS_GAIN_LSB +: 6];
  assign next_ctrl.mode = acris_mode_t'(pwdata[ACRIS_MODE_LSB +: 2]);

  // APB slave: answers in the first access cycle, unmapped gives pslverr
  assign next_pslverr = bus_setup && !hit_any;
  assign next_prdata = (bus_setup && !pwrite) ? read_mux : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= bus_setup;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.sel <= ACRIS_SEL_RESET;
      ctrl.gain <= ACRIS_GAIN_RESET;
      ctrl.mode <= ACRIS_SLAVE;
    end else if (bus_write && hit_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // selections reach the front end the cycle after the write, no boundary wait
  // no zero-cross or ramp here; downstream must mute around changes
  assign sel_mute = (ctrl.sel == ACRIS_SEL_MUTE_LO) || (ctrl.sel == ACRIS_SEL_MUTE_HI);
  assign next_select = sel_mute ? 3'h0 : ctrl.sel;
  assign gain_mute = (ctrl.gain < ACRIS_GAIN_MIN) || (ctrl.gain > ACRIS_GAIN_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select <= ACRIS_SEL_RESET;
      input_mute <= 1'b0;
      pga_gain <= ACRIS_GAIN_RESET;
      pga_mute <= 1'b0;
    end else begin
      input_select <= next_select;
      input_mute <= sel_mute;
      pga_gain <= ctrl.gain;
      pga_mute <= gain_mute;
    end
  end

  // master clock sampled as a level; a rising edge is one system clock
  assign mclk_tick = master_clock_in && !mclk_prev;
  assign frame_rise = frame_clock_in && !frame_prev;
  assign is_master = (ctrl.mode != ACRIS_SLAVE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_prev <= 1'b0;
      frame_prev <= 1'b0;
    end else begin
      mclk_prev <= master_clock_in;
      frame_prev <= frame_clock_in;
    end
  end

  // classify master clocks per frame into the four ratios
  assign next_detected = (tick_count < ACRIS_LIM_320) ? ACRIS_R256 :
                         (tick_count < ACRIS_LIM_448) ? ACRIS_R384 :
                         (tick_count < ACRIS_LIM_640) ? ACRIS_R512 : ACRIS_R768;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= 10'h000;
      period_count <= 16'h0000;
      frame_period <= 16'hffff;
      detected_ratio <= ACRIS_R256;
      ratio_seen <= 1'b0;
    end else if (is_master) begin
      // no detection in master mode, the host sets the ratio
      tick_count <= 10'h000;
      period_count <= 16'h0000;
      ratio_seen <= 1'b0;
    end else if (frame_rise) begin
      detected_ratio <= next_detected;
      ratio_seen <= 1'b1;
      frame_period <= period_count;
      tick_count <= mclk_tick ? 10'h001 : 10'h000;
      period_count <= 16'h0001;
    end else begin
      // saturate so a stopped frame clock does not wrap the measure
      if (mclk_tick && tick_count != 10'h3ff) begin
        tick_count <= 10'(tick_count + 10'h001);
      end
      if (period_count != 16'hffff) begin
        period_count <= 16'(period_count + 16'h0001);
      end
    end
  end

  assign active_ratio = !is_master ? detected_ratio :
                        (ctrl.mode == ACRIS_MASTER_256) ? ACRIS_R256 :
                        (ctrl.mode == ACRIS_MASTER_384) ? ACRIS_R384 : ACRIS_R512;

  // 768x at 88.2 kHz or faster is flagged, yet the divider still runs at 768x
  assign ratio_err = !is_master && ratio_seen && (detected_ratio == ACRIS_R768) &&
                     (frame_period <= ACRIS_FS_LIMIT_CYCLES);

  // count master clocks from supply good, restart on its loss
  assign hold_done = (hold_count == ACRIS_HOLD_CLOCKS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_count <= 11'h000;
    end else if (!supply_good) begin
      hold_count <= 11'h000;
    end else if (mclk_tick && !hold_done) begin
      hold_count <= 11'(hold_count + 11'h001);
    end
  end

  acris_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(core_reset),
    .tick(mclk_tick),
    .ratio(active_ratio),
    .clks(clks)
  );

  // frame source is the generated clock in master mode, the pin in slave
  assign frame_event = is_master ? clks.frame_tick : frame_rise;
  assign valid_done = (valid_count == 13'(VALID_FRAMES));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_count <= 13'h0000;
    end else if (core_reset) begin
      valid_count <= 13'h0000;
    end else if (frame_event && !valid_done) begin
      valid_count <= 13'(valid_count + 13'h0001);
    end
  end

  // loss of supply wins over every other step, from any state
  // settle ends only on counted frames; a stalled frame clock keeps data invalid
  always_comb begin
    next_pwr = pwr_state;
    case (pwr_state)
      ACRIS_PWR_HOLD: begin
        if (hold_done) begin
          next_pwr = ACRIS_PWR_SETTLE;
        end
      end
      ACRIS_PWR_SETTLE: begin
        if (valid_done) begin
          next_pwr = ACRIS_PWR_VALID;
        end
      end
      ACRIS_PWR_VALID: begin
        next_pwr = ACRIS_PWR_VALID;
      end
      default: begin
        next_pwr = ACRIS_PWR_HOLD;
      end
    endcase
    if (!supply_good) begin
      next_pwr = ACRIS_PWR_HOLD;
    end
  end

  assign next_core_reset = (next_pwr == ACRIS_PWR_HOLD);
  assign next_data_valid = (next_pwr == ACRIS_PWR_VALID);

  // release timed by the bus clock, so a master clock stopped after the
  // last hold edge still lets reset go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state <= ACRIS_PWR_HOLD;
      core_reset <= 1'b1;
      data_valid <= 1'b0;
    end else begin
      pwr_state <= next_pwr;
      core_reset <= next_core_reset;
      data_valid <= next_data_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out <= 24'h00_0000;
      sample_out_strobe <= 1'b0;
    end else begin
      sample_out_strobe <= sample_strobe;
      if (!next_data_valid) begin
        sample_out <= 24'h00_0000;
      end else if (sample_strobe) begin
        sample_out <= sample_in;
      end
    end
  end

  // clock pins: driven only in master mode, inputs unused beyond sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_clock_out <= 1'b0;
      bit_clock_oe <= 1'b0;
      frame_clock_out <= 1'b0;
      frame_clock_oe <= 1'b0;
      filter_clk <= 1'b0;
      mod_clk <= 1'b0;
    end else begin
      bit_clock_out <= is_master && clks.mod_clk;
      bit_clock_oe <= is_master;
      frame_clock_out <= is_master && clks.frame_clk;
      frame_clock_oe <= is_master;
      filter_clk <= clks.filter_clk;
      mod_clk <= clks.mod_clk;
    end
  end

  // slave bit clock is accepted but not needed by this block
  wire logic unused_bit_clock;
  assign unused_bit_clock = bit_clock_in;
endmodule

/* File: sim/acris_sva.sv */
// port assertions for the converter clock, reset and input-select block
`timescale 1ns/10ps
module acris_sva
  import acris_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic master_clock_in,
  input wire logic supply_good,
  input wire logic bit_clock_oe,
  input wire logic frame_clock_oe,
  input wire logic core_reset,
  input wire logic [2:0] input_select,
  input wire logic input_mute,
  input wire logic [5:0] pga_gain,
  input wire logic pga_mute,
  input wire logic [23:0] sample_out,
  input wire logic data_valid
);
  logic mclk_q;
  logic [11:0] hold_cnt;
  logic [2:0] sel_w;
  logic [5:0] gain_w;
  logic [1:0] mode_w;
  wire wr_ctrl = psel && penable && pready && pwrite && (paddr == ACRIS_CTRL_ADDR);
  wire sel_mute = (sel_w == 3'h0) || (sel_w == 3'h7);
  wire gain_ok = (gain_w >= ACRIS_GAIN_MIN) && (gain_w <= ACRIS_GAIN_MAX);
  // saturates so a long run never wraps back under the hold limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_q <= 1'b0;
      hold_cnt <= 12'h000;
    end else begin
      mclk_q <= master_clock_in;
      if (!supply_good)
        hold_cnt <= 12'h000;
      else if (master_clock_in && !mclk_q && hold_cnt != 12'hfff)
        hold_cnt <= hold_cnt + 12'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_w <= 3'h1;
      gain_w <= 6'h0a;
      mode_w <= 2'h0;
    end else if (wr_ctrl) begin
      sel_w <= pwdata[2:0];
      gain_w <= pwdata[9:4];
      mode_w <= pwdata[13:12];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZERO_IN_RESET: assert property (core_reset |-> sample_out == 24'h00_0000)
    else $error("sample out not zero in reset");
  AST_ZERO_INVALID: assert property (!data_valid |-> sample_out == 24'h00_0000)
    else $error("sample out not zero while invalid");
  AST_SUPPLY_LOST: assert property (!supply_good |=> core_reset)
    else $error("core reset low without supply");
  AST_VALID_CLEAR: assert property (core_reset |=> !data_valid)
    else $error("data valid during reset");
  AST_HOLD_COUNT: assert property ($fell(core_reset) |-> hold_cnt == 12'h400)
    else $error("reset released at wrong tick count");
  AST_HOLD_MAX: assert property (hold_cnt >= 12'h401 |-> !core_reset)
    else $error("reset held too long");
  AST_OE_PAIR: assert property (bit_clock_oe == frame_clock_oe)
    else $error("bit and frame enables differ");
  AST_OE_MODE: assert property (wr_ctrl |-> ##2 (bit_clock_oe == (mode_w != 2'h0)))
    else $error("clock pin enable does not follow mode");
  AST_SEL_APPLY: assert property (wr_ctrl |-> ##2 input_select == (sel_mute ? 3'h0 : sel_w))
    else $error("input select not applied");
  AST_MUTE_APPLY: assert property (wr_ctrl |-> ##2 input_mute == sel_mute)
    else $error("input mute wrong");
  AST_GAIN_APPLY: assert property (wr_ctrl |-> ##2 (pga_gain == gain_w && pga_mute == !gain_ok))
    else $error("gain not applied");
endmodule

/* File: sim/acris_host.sv */
// clock source model: master clock at a set ratio, slave bit and frame clocks
`timescale 1ns/10ps
module acris_host (
  input wire logic pclk,
  input wire logic run,
  input wire logic [9:0] ratio,
  output logic mclk,
  output logic fclk,
  output logic bclk
);
  logic [1:0] ph = 2'h0;
  logic [9:0] tk = 10'h000;
  initial begin
    mclk = 1'b0;
    fclk = 1'b0;
    bclk = 1'b0;
  end
  // master clock at a quarter of pclk so every edge is seen; stands still when stopped
  always @(posedge pclk) begin
    if (run) begin
      ph <= ph + 2'h1;
      mclk <= ph[1];
      if (ph == 2'h1)
        tk <= (tk >= ratio - 10'h001) ? 10'h000 : tk + 10'h001;
      fclk <= tk < ratio / 2;
      bclk <= (tk % (ratio / 64)) < ratio / 128;
    end else begin
      mclk <= 1'b0;
    end
  end
endmodule

/* File: sim/acris_top_tb.sv */
// self-checking bench for the converter clock, reset and input-select block
`timescale 1ns/10ps
module acris_top_tb
  import acris_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, master_clock_in, supply_good;
  logic bit_clock_in, frame_clock_in, bit_clock_out, bit_clock_oe, frame_clock_out;
  logic frame_clock_oe, filter_clk, mod_clk, core_reset, input_mute, pga_mute, err, run;
  logic sample_strobe, sample_out_strobe, data_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] input_select;
  logic [5:0] pga_gain, g;
  logic [23:0] sample_in, sample_out;
  logic [9:0] ratio;
  logic [23:0] exq[$];
  int num_errors = 0;
  int compares = 0;
  int seed = 97386;
  int rt[4] = '{256, 384, 512, 768};
  // short valid delay keeps the run brief
  acris_top #(.VALID_FRAMES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clock_in(master_clock_in), .supply_good(supply_good),
    .bit_clock_in(bit_clock_in), .frame_clock_in(frame_clock_in),
    .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
    .frame_clock_out(frame_clock_out), .frame_clock_oe(frame_clock_oe),
    .filter_clk(filter_clk), .mod_clk(mod_clk), .core_reset(core_reset),
    .input_select(input_select), .input_mute(input_mute), .pga_gain(pga_gain),
    .pga_mute(pga_mute), .sample_in(sample_in), .sample_strobe(sample_strobe),
    .sample_out(sample_out), .sample_out_strobe(sample_out_strobe), .data_valid(data_valid)
  );
  acris_host u_host (.pclk(pclk), .run(run), .ratio(ratio), .mclk(master_clock_in),
    .fclk(frame_clock_in), .bclk(bit_clock_in));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input int n);
    logic [23:0] d;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      d = 24'($random(seed));
      sample_in <= d;
      sample_strobe <= 1'b1;
      exq.push_back((data_valid === 1'b1 && core_reset === 1'b0) ? d : 24'h00_0000);
      @(posedge pclk);
      sample_strobe <= 1'b0;
    end
  endtask
  // counts rises of the derived clocks over one frame period
  task automatic meas(input int r, input logic own);
    int n, nb, nf, nm;
    logic f, pf, pb, pfc, pm;
    f = 1'b1;
    pf = 1'b1;
    while (!(f && !pf)) begin
      pf = f;
      @(posedge pclk);
      f = own ? frame_clock_out : frame_clock_in;
    end
    n = 0;
    nb = 0;
    nf = 0;
    nm = 0;
    pb = bit_clock_out;
    pfc = filter_clk;
    pm = mod_clk;
    do begin
      @(posedge pclk);
      n++;
      pf = f;
      f = own ? frame_clock_out : frame_clock_in;
      nb += int'(bit_clock_out && !pb);
      nf += int'(filter_clk && !pfc);
      nm += int'(mod_clk && !pm);
      pb = bit_clock_out;
      pfc = filter_clk;
      pm = mod_clk;
    end while (!(f && !pf));
    chk(n, r * 4);
    chk(nf, 128);
    chk(nm, 64);
    if (own)
      chk(nb, 64);
  endtask
  always @(negedge pclk) begin
    if (sample_out_strobe === 1'b1) begin
      if (exq.size() == 0)
        chk(32'h0000_0001, 32'h0000_0000);
      else
        chk({8'h00, sample_out}, {8'h00, exq.pop_front()});
    end
  end
  initial begin
    repeat (95000) @(posedge pclk);
    num_errors++;
    $display("[ERR] %0t watchdog got %h exp %h", $time, 0, 1);
    final_report();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    supply_good = 1'b0;
    sample_in = 24'h00_0000;
    sample_strobe = 1'b0;
    run = 1'b1;
    ratio = 10'h100;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(input_select, 3'h1);
    chk(core_reset, 1'b1);
    apb(1'b0, ACRIS_CTRL_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_00a1);
    apb(1'b0, ACRIS_ID_ADDR, 32'h0000_0000);
    chk(rd, ACRIS_ID_VALUE);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    send(3);
    supply_good <= 1'b1;
    repeat (600) @(posedge master_clock_in);
    supply_good <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(core_reset, 1'b1);
    supply_good <= 1'b1;
    repeat (1024) @(posedge master_clock_in);
    // stop the master clock right at the last counted edge
    run <= 1'b0;
    chk(core_reset, 1'b1);
    repeat (4) @(posedge pclk);
    chk(core_reset, 1'b0);
    run <= 1'b1;
    repeat (3) @(posedge frame_clock_in);
    repeat (2) @(posedge pclk);
    chk(data_valid, 1'b0);
    @(posedge frame_clock_in);
    repeat (6) @(posedge pclk);
    chk(data_valid, 1'b1);
    send(6);
    for (int i = 0; i < 8; i++) begin
      g = (i == 0) ? 6'h09 : (i == 7) ? 6'h37 : 6'(ACRIS_GAIN_MIN + $unsigned($random(seed)) % 45);
      apb(1'b1, ACRIS_CTRL_ADDR, {20'h0_0000, 2'b00, g, 1'b0, 3'(i)});
      repeat (2) @(posedge pclk);
      chk(input_select, (i == 0 || i == 7) ? 3'h0 : 3'(i));
      chk(input_mute, i == 0 || i == 7);
      chk(pga_gain, g);
      chk(pga_mute, i == 0 || i == 7);
    end
    for (int r = 0; r < 4; r++) begin
      ratio <= 10'(rt[r]);
      repeat (3) @(posedge frame_clock_in);
      apb(1'b0, ACRIS_STATUS_ADDR, 32'h0000_0000);
      chk(rd & 32'h0000_007f, 32'h0000_0044 | r);
      chk(bit_clock_oe, 1'b0);
      meas(rt[r], 1'b0);
    end
    // master modes only at 256, 384 and 512
    for (int m = 1; m < 4; m++) begin
      ratio <= 10'(rt[m - 1]);
      apb(1'b1, ACRIS_CTRL_ADDR, {18'h0_0000, 2'(m), 12'h0a1});
      repeat (3) @(posedge frame_clock_out);
      apb(1'b0, ACRIS_STATUS_ADDR, 32'h0000_0000);
      chk(rd & 32'h0000_000b, 32'h0000_0008 | (m - 1));
      chk(bit_clock_oe & frame_clock_oe, 1'b1);
      meas(rt[m - 1], 1'b1);
    end
    chk(exq.size(), 0);
    final_report();
  end
endmodule
bind acris_top acris_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .master_clock_in(master_clock_in),
  .supply_good(supply_good), .bit_clock_oe(bit_clock_oe), .frame_clock_oe(frame_clock_oe),
  .core_reset(core_reset), .input_select(input_select), .input_mute(input_mute),
  .pga_gain(pga_gain), .pga_mute(pga_mute), .sample_out(sample_out), .data_valid(data_valid)
);
